// file: logic/frs_result_status.sv
// Result-phase status bytes and reset control of the floppy core.
// Assumes a command engine on i_clk reports events, and pins arrive asynchronously.
//
// Functional notes
// - Result bytes read through data register.
// - Byte0 bits7:6 give termination code.
// - Byte0 bit5 set at travel end.
// - Byte0 bit4 on recal 80 steps fail.
// - Byte0: bit3 zero, head, unit select.
// - Byte1 bit7 beyond final sector.
// - Byte1 bit5 on any CRC fault.
// - Byte1 bit4 on overrun or underrun.
// - Byte1 bit2 sector missing.
// - Byte1 bit1 write protect during write.
// - Byte1 bit0 no ID mark, two indexes.
// - Unused status bits read fixed constants.
// - Byte2 bit6 on data mark mismatch.
// - Byte2 bit5 on payload CRC fault.
// - Byte2 bit4 on track mismatch.
// - Byte2 bit0 no payload mark.
// - Byte3 shows pin states captured at termination.
// - Pin, two register bits, power-on reset.
// - Reset ends operations, device goes idle.
// - Reset exit clears configuration registers.
// - Polling starts after reset unless disabled.
// - Pin reset sets register reset bit.
// - Rate reset self-clears; drive reset dominates.
`timescale 1ns/1ps
module frs_result_status
  import frs_pkg::*;
(
  input  wire logic          i_clk,            // 50 MHz clock.
  input  wire logic          i_nrst,           // Pin and power-on reset, active low.
  input  wire logic          i_dor_wr,         // Drive output register write strobe.
  input  wire logic          i_dor_reset_wdat, // Written reset bit value, 0 holds reset.
  input  wire logic          i_dsr_wr,         // Rate select register write strobe.
  input  wire logic          i_dsr_reset_wdat, // Written rate reset bit, 1 starts reset.
  input  wire logic          i_cmd_start,      // Command engine begins execution.
  input  wire logic          i_cmd_done,       // Command terminates, result phase begins.
  input  wire logic [1:0]    i_term_code,      // Termination code of this command.
  input  wire frs_event_type i_evt,            // Fault events of the running command.
  input  wire logic [1:0]    i_result_count,   // Result bytes minus one for this command.
  input  wire logic          i_data_rd,        // Host reads the data register.
  input  wire logic          i_cfg_wr,         // Configure command loads settings.
  input  wire logic          i_cfg_poll_off,   // Configure value: disable drive polling.
  input  wire logic          i_write_protect,  // Write-protect pin, asynchronous.
  input  wire logic          i_track_zero_in,  // Track-zero pin, asynchronous.
  input  wire logic          i_head_select_out,// Head select drive, same clock.
  input  wire logic [1:0]    i_unit_select,    // Drive select outputs, same clock.
  output logic [7:0]         o_data,           // Result byte on the data register.
  output logic               o_result_ready,   // Result bytes await reading.
  output logic               o_core_reset,     // Core held in reset, ends all work.
  output logic               o_dor_reset,      // Read back of the drive reset bit.
  output logic               o_poll_enable,    // Drive polling active.
  output logic               o_powerdown_exit  // Pulse: any reset left power-down.
);

  // Pin synchronisers, two stages each before any logic reads them.
  logic [1:0] wp_sync_reg;     // Write-protect synchroniser.
  logic [1:0] track_zero_in_sync_reg;   // Track-zero synchroniser.
  logic       wp_live;         // Synchronised write protect.
  logic       track_zero_in_live;       // Synchronised track zero.

  // Reset control state.
  logic       dor_reset_reg;   // Host-cleared reset bit.
  logic       dsr_reset_reg;   // Self-clearing reset bit.
  logic       core_reset_next; // Combined software reset.
  logic       core_reset_reg;  // Registered core reset.
  logic       poll_reg;        // Polling enable.
  logic       pdx_reg;         // Power-down exit pulse.

  // Accumulated fault flags of the command in flight.
  logic       travel_reg, equip_reg, end_trk_reg, crc_any_reg, ovr_reg;
  logic       miss_reg, wblock_reg, id_abs_reg, mark_reg, crc_pay_reg;
  logic       trk_mis_reg, bad_trk_reg, no_mark_reg;
  logic [6:0] step_cnt_reg;    // Recalibrate steps seen without track zero.
  logic [1:0] index_cnt_reg;   // Index pulses seen without an ID mark.
  logic [7:0] track_reg;       // Internally maintained track number.

  // Result bytes frozen at command termination.
  logic [7:0]    res_reg [4];  // Captured status bytes 0 to 3.
  logic [1:0]    rd_idx_reg;   // Byte now presented.
  logic [1:0]    last_idx_reg; // Last byte of this command.
  frs_state_type state_reg;    // Result phase state.
  frs_state_type state_next;   // Next result phase state.
  logic [7:0]    data_reg;     // Byte on the data register.

  // Live assembled status bytes.
  wire [7:0] st0_live;
  wire [7:0] st1_live;
  wire [7:0] st2_live;
  wire [7:0] st3_live;
  wire       recal_fail;
  wire       idx_twice;
  wire       trk_differs;
  wire       clear_flags;
  wire       last_read;

  assign wp_live   = wp_sync_reg[1];
  assign track_zero_in_live = track_zero_in_sync_reg[1];

  // Only the second stage is read by logic; the first is metastability guard.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_sync_reg   <= 2'h0;
      track_zero_in_sync_reg <= 2'h0;
    end else begin
      wp_sync_reg   <= {wp_sync_reg[0], i_write_protect};
      track_zero_in_sync_reg <= {track_zero_in_sync_reg[0], i_track_zero_in};
    end
  end

  // The drive reset bit dominates; the rate reset only lasts one cycle.
  assign core_reset_next = dor_reset_reg | dsr_reset_reg;

  // Pin reset sets the drive reset bit; host writes 1 to leave reset.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dor_reset_reg  <= 1'h1;
      dsr_reset_reg  <= 1'h0;
      core_reset_reg <= 1'h1;
      pdx_reg        <= 1'h0;
    end else begin
      if (i_dor_wr) begin
        dor_reset_reg <= ~i_dor_reset_wdat;
      end
      // Self-clears on the next cycle unless written again.
      dsr_reset_reg  <= i_dsr_wr & i_dsr_reset_wdat;
      core_reset_reg <= core_reset_next;
      // Leaving any reset also leaves power-down.
      pdx_reg        <= core_reset_reg & ~core_reset_next;
    end
  end

  // Configure settings are cleared by every reset; polling restarts on exit.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      poll_reg <= 1'h0;
    end else if (core_reset_reg) begin
      poll_reg <= 1'h1;
    end else if (i_cfg_wr) begin
      poll_reg <= ~i_cfg_poll_off;
    end
  end

  // Fault detection terms.
  assign recal_fail  = i_evt.recal_step & ~track_zero_in_live
                       & (step_cnt_reg == 7'(`FRS_RECAL_STEPS - 8'h01));
  assign idx_twice   = i_evt.index_pulse_in & ~i_evt.id_found
                       & (index_cnt_reg == 2'h1);
  assign trk_differs = i_evt.id_valid & (i_evt.id_track != track_reg);
  assign clear_flags = core_reset_reg | i_cmd_start;

  // Sticky flags per command; events in the clearing cycle still set them.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      {travel_reg, equip_reg, end_trk_reg, crc_any_reg, ovr_reg} <= 5'h00;
      {miss_reg, wblock_reg, id_abs_reg, mark_reg, crc_pay_reg}  <= 5'h00;
      {trk_mis_reg, bad_trk_reg, no_mark_reg}                    <= 3'h0;
      step_cnt_reg  <= 7'h00;
      index_cnt_reg <= 2'h0;
    end else begin
      travel_reg  <= (travel_reg & ~clear_flags) | i_evt.travel_done;
      equip_reg   <= (equip_reg & ~clear_flags) | recal_fail
                     | i_evt.step_past_zero;
      end_trk_reg <= (end_trk_reg & ~clear_flags) | i_evt.sector_beyond
                     | i_evt.no_terminal;
      crc_any_reg <= (crc_any_reg & ~clear_flags) | i_evt.crc_id
                     | i_evt.crc_payload;
      ovr_reg     <= (ovr_reg & ~clear_flags) | i_evt.overrun;
      miss_reg    <= (miss_reg & ~clear_flags) | i_evt.sector_missing;
      wblock_reg  <= (wblock_reg & ~clear_flags) | (i_evt.write_cmd & wp_live);
      id_abs_reg  <= (id_abs_reg & ~clear_flags) | idx_twice
                     | i_evt.payload_mark_miss;
      mark_reg    <= (mark_reg & ~clear_flags) | i_evt.mark_mismatch;
      crc_pay_reg <= (crc_pay_reg & ~clear_flags) | i_evt.crc_payload;
      trk_mis_reg <= (trk_mis_reg & ~clear_flags) | trk_differs;
      bad_trk_reg <= (bad_trk_reg & ~clear_flags)
                     | (trk_differs & (i_evt.id_track == `FRS_BAD_TRACK_ID));
      no_mark_reg <= (no_mark_reg & ~clear_flags) | i_evt.payload_mark_miss;
      // Step counter restarts at track zero or on a new command.
      if (clear_flags || track_zero_in_live) begin
        step_cnt_reg <= 7'h00;
      end else if (i_evt.recal_step && step_cnt_reg != 7'(`FRS_RECAL_STEPS)) begin
        step_cnt_reg <= step_cnt_reg + 7'h01;
      end
      if (clear_flags || i_evt.id_found) begin
        index_cnt_reg <= 2'h0;
      end else if (i_evt.index_pulse_in && index_cnt_reg != 2'h2) begin
        index_cnt_reg <= index_cnt_reg + 2'h1;
      end
    end
  end

  // The internal track number clears at track zero and takes any valid ID track at travel end.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      track_reg <= `FRS_BYTE_ZERO;
    end else if (core_reset_reg || track_zero_in_live) begin
      track_reg <= `FRS_BYTE_ZERO;
    end else if (i_evt.travel_done && i_evt.id_valid) begin
      track_reg <= i_evt.id_track;
    end
  end

  // Live status bytes; fixed bits are constants.
  assign st0_live = {i_term_code, travel_reg, equip_reg, 1'b0,
                     i_head_select_out, i_unit_select};
  assign st1_live = {end_trk_reg, 1'b0, crc_any_reg, ovr_reg, 1'b0,
                     miss_reg, wblock_reg, id_abs_reg};
  assign st2_live = {1'b0, mark_reg, crc_pay_reg, trk_mis_reg, 2'b00,
                     bad_trk_reg, no_mark_reg};
  assign st3_live = {1'b0, wp_live, 1'b1, track_zero_in_live, 1'b1,
                     i_head_select_out, i_unit_select};

  assign last_read = i_data_rd && (rd_idx_reg == last_idx_reg);

  // Result phase sequencing.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FRS_IDLE:    if (i_cmd_done) state_next = FRS_CAPTURE;
      FRS_CAPTURE: state_next = FRS_READING;
      FRS_READING: if (last_read) state_next = FRS_IDLE;
    endcase
    if (core_reset_reg) begin
      state_next = FRS_IDLE;
    end
  end

  // Capture freezes the bytes so later events cannot alter a pending result.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg    <= FRS_IDLE;
      rd_idx_reg   <= 2'h0;
      last_idx_reg <= 2'h0;
      data_reg     <= `FRS_BYTE_ZERO;
      for (int i = 0; i < 4; i++) res_reg[i] <= `FRS_BYTE_ZERO;
    end else begin
      state_reg <= state_next;
      if (core_reset_reg) begin
        rd_idx_reg <= 2'h0;
        data_reg   <= `FRS_BYTE_ZERO;
      end else if (state_reg == FRS_IDLE && i_cmd_done) begin
        res_reg[0]   <= st0_live;
        res_reg[1]   <= st1_live;
        res_reg[2]   <= st2_live;
        res_reg[3]   <= st3_live;
        last_idx_reg <= i_result_count;
        rd_idx_reg   <= 2'h0;
      end else if (state_reg == FRS_CAPTURE) begin
        data_reg <= res_reg[0];
      end else if (state_reg == FRS_READING && i_data_rd && !last_read) begin
        data_reg   <= res_reg[rd_idx_reg + 2'h1];
        rd_idx_reg <= rd_idx_reg + 2'h1;
      end
    end
  end

  // Every output is a flip-flop; ready is the upper state bit, set only in reading.
  assign o_data           = data_reg;
  assign o_result_ready   = state_reg[1];
  assign o_core_reset     = core_reset_reg;
  assign o_dor_reset      = dor_reset_reg;
  assign o_poll_enable    = poll_reg;
  assign o_powerdown_exit = pdx_reg;


  // The rate reset lasts one cycle once its write is gone.
  a_dsr_self_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_dsr_wr && i_dsr_reset_wdat && !dor_reset_reg ##1 !i_dsr_wr |=> !dsr_reset_reg)
    else $error("Rate reset did not clear itself.");

  // The drive reset bit keeps the core in reset.
  a_dor_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    dor_reset_reg && !i_dor_wr |=> core_reset_reg)
    else $error("Drive reset bit did not hold the core.");

  // Any core reset drops a pending result.
  a_reset_idle: assert property (@(posedge i_clk) disable iff (!i_nrst)
    core_reset_reg |=> state_reg == FRS_IDLE)
    else $error("Reset did not return the result phase to idle.");

  // Polling runs as the core leaves reset.
  a_poll_restart: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(core_reset_reg) |-> poll_reg)
    else $error("Polling not enabled after reset.");

  // The first byte stands two edges after termination.
  a_first_byte: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == FRS_IDLE && i_cmd_done && !core_reset_reg ##1 !core_reset_reg
    |=> o_data == res_reg[0] && o_result_ready)
    else $error("First result byte not presented.");

  // Captured byte one stays frozen while the host reads.
  a_hold_bytes: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == FRS_READING && !core_reset_reg |=> $stable(res_reg[1]))
    else $error("Result bytes changed before being read.");

  // Byte three carries its fixed ones and zero.
  a_st3_const: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == FRS_CAPTURE |-> res_reg[3][7] == 1'b0 && res_reg[3][5] && res_reg[3][3])
    else $error("Fixed bits of byte three are wrong.");

  // A differing all-ones track is a bad track.
  a_bad_track: assert property (@(posedge i_clk) disable iff (!i_nrst)
    trk_differs && i_evt.id_track == `FRS_BAD_TRACK_ID |=> bad_trk_reg && trk_mis_reg)
    else $error("Bad track not flagged.");

  // Write protect during a write blocks it.
  a_write_block: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_evt.write_cmd && wp_live |=> wblock_reg)
    else $error("Write protect during write not flagged.");

  // Reading the last byte ends the result phase.
  a_ready_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == FRS_READING && last_read && !core_reset_reg |=> !o_result_ready)
    else $error("Result phase did not end after the last byte.");

  // Unused bits of bytes zero to two read zero.
  a_fixed_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == FRS_CAPTURE |-> res_reg[0][3] == 1'b0 && res_reg[1][6] == 1'b0
    && res_reg[1][3] == 1'b0 && res_reg[2][7] == 1'b0 && res_reg[2][3:2] == 2'b00)
    else $error("Fixed zero bits are wrong.");

  // A travel end sets its flag at the next edge.
  a_travel_end: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_evt.travel_done |=> travel_reg)
    else $error("Travel end not flagged.");

  // A differing ID track sets the mismatch flag.
  a_trk_mismatch: assert property (@(posedge i_clk) disable iff (!i_nrst)
    trk_differs |=> trk_mis_reg)
    else $error("Track mismatch not flagged.");

endmodule : frs_result_status

// file: logic/frs_map.svh
// Constants for the floppy result-status and reset block.
// Assumes inclusion by the package and the design module only.
`ifndef FRS_MAP_SVH
`define FRS_MAP_SVH
// Termination codes carried in status byte 0 bits 7:6.
`define FRS_TERM_NORMAL   2'h0
`define FRS_TERM_ABNORMAL 2'h1
`define FRS_TERM_INVALID  2'h2
`define FRS_TERM_POLLING  2'h3
// Bit positions inside the status bytes.
`define FRS_S0_TRAVEL     5
`define FRS_S0_EQUIP      4
`define FRS_S0_HEAD       2
`define FRS_S1_END_TRACK  7
`define FRS_S1_CRC_ANY    5
`define FRS_S1_OVERRUN    4
`define FRS_S1_MISSING    2
`define FRS_S1_WBLOCK     1
`define FRS_S1_ID_ABSENT  0
`define FRS_S2_MARK_MIS   6
`define FRS_S2_CRC_PAY    5
`define FRS_S2_TRK_MIS    4
`define FRS_S2_BAD_TRK    1
`define FRS_S2_NO_MARK    0
`define FRS_S3_WP         6
`define FRS_S3_TRACK_ZERO_IN       4
`define FRS_S3_HEAD       2
// Track limits used by the fault logic.
`define FRS_RECAL_STEPS   8'h50
`define FRS_BAD_TRACK_ID  8'hff
`define FRS_LAST_SECTOR   8'hff
// Result byte count and reset value of the result registers.
`define FRS_RESULT_LAST   2'h3
`define FRS_BYTE_ZERO     8'h00
`endif

// file: logic/frs_pkg.sv
// Types shared by the floppy result-status and reset block.
// Assumes frs_map.svh is on the include path.
`include "frs_map.svh"
package frs_pkg;
  // Fault events reported by the command engine for one command.
  typedef struct packed {
    logic       travel_done;       // Seek, relative seek or recalibrate finished.
    logic       recal_step;        // One recalibrate step pulse was issued.
    logic       step_past_zero;    // A relative seek stepped outward past track zero.
    logic       sector_beyond;     // Access beyond the final sector.
    logic       no_terminal;       // Read/write data ended without terminal count.
    logic       crc_id;            // CRC mismatch in an ID field.
    logic       crc_payload;       // CRC mismatch in a data field.
    logic       overrun;           // Transfer not serviced in time.
    logic       sector_missing;    // Sector, ID or sequence not found.
    logic       write_cmd;         // A write or format command is executing.
    logic       index_pulse_in;    // Index pulse seen while hunting an ID mark.
    logic       id_found;          // An ID address mark was found.
    logic       payload_mark_miss; // No data or deleted-data mark found.
    logic       mark_mismatch;     // Wrong kind of data mark met.
    logic       id_valid;          // An ID track number is offered.
    logic [7:0] id_track;          // Track number read from the ID.
  } frs_event_type;
  // Result-phase states, Gray coded along idle, capture, reading.
  typedef enum logic [1:0] {
    FRS_IDLE    = 2'b00,
    FRS_CAPTURE = 2'b01,
    FRS_READING = 2'b11
  } frs_state_type;
endpackage : frs_pkg

// file: verification/frs_host_model.sv
// Host model that drains result bytes through the data register.
// Assumes the block's ready flag and result byte share the host's clock.
`timescale 1ns/1ps
module frs_host_model (
  input  wire logic       i_clk,    // System clock.
  input  wire logic       i_nrst,   // Reset, active low.
  input  wire logic       i_go,     // Drain results while high.
  input  wire logic [2:0] i_nbytes, // Number of bytes to take.
  input  wire logic [3:0] i_gap,    // Idle cycles between reads.
  input  wire logic       i_ready,  // Result bytes await reading.
  input  wire logic [7:0] i_data,   // Presented result byte.
  output logic            o_rd,     // Data register read strobe.
  output logic [31:0]     o_bytes,  // Bytes taken, first one in the low bits.
  output logic [2:0]      o_count   // Number of bytes taken.
);
  logic [3:0] wait_reg; // Idle cycles left before the next read.

  // A read is held until it meets ready, and the byte is taken at that edge.
  // A slow host waits between reads so that held values can be seen standing.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rd     <= 1'b0;
      o_bytes  <= 32'h0;
      o_count  <= 3'h0;
      wait_reg <= 4'h0;
    end else if (!i_go) begin
      o_rd     <= 1'b0;
      o_count  <= 3'h0;
      wait_reg <= 4'h0;
    end else if (o_rd && i_ready) begin
      o_bytes[o_count*8 +: 8] <= i_data;
      o_count  <= o_count + 3'h1;
      o_rd     <= (i_gap == 4'h0) && (o_count + 3'h1 < i_nbytes);
      wait_reg <= i_gap;
    end else if (!o_rd && i_ready && o_count < i_nbytes) begin
      if (wait_reg == 4'h0) begin
        o_rd <= 1'b1;
      end else begin
        wait_reg <= wait_reg - 4'h1;
      end
    end
  end
endmodule : frs_host_model

// file: verification/test_frs_result_status.sv
// Self-checking bench for the result-status and reset block.
// Assumes the host model drains results; every other input is driven here.
`timescale 1ns/1ps
module test_frs_result_status;
  import frs_pkg::*;
  logic          i_clk = 1'b0, i_nrst = 1'b0;            // Clock and pin reset.
  logic          dor_wr = 1'b0, dor_wdat = 1'b0;         // Drive register writes.
  logic          dsr_wr = 1'b0, dsr_wdat = 1'b0;         // Rate register writes.
  logic          cmd_start = 1'b0, cmd_done = 1'b0;      // Command engine strobes.
  logic          cfg_wr = 1'b0, cfg_off = 1'b0;          // Configure write.
  logic          wp = 1'b0, t0 = 1'b0, head = 1'b0;      // Pin levels.
  logic [1:0]    unit = 2'h0, term = 2'h0, cnt = 2'h0;   // Unit, code, count.
  frs_event_type evt = '0;                               // Event pulses.
  logic          host_go = 1'b0, host_rd;                // Host control and strobe.
  logic [2:0]    host_n = 3'h0, host_cnt;                // Bytes wanted and taken.
  logic [3:0]    host_gap = 4'h0;                        // Host pacing.
  logic [31:0]   host_bytes;                             // Bytes the host took.
  logic [7:0]    o_data;                                 // Result byte.
  logic          o_ready, o_core_reset, o_dor_reset, o_poll, o_pdx;
  int            failures = 0, compares = 0, pdx_count = 0;
  // Flags expected per table entry: byte0 bits 5:4, byte1, byte2.
  logic [17:0]   tab [19] = '{18'h08000, 18'h08000, 18'h02000, 18'h02020, 18'h01000,
    18'h00400, 18'h00200, 18'h0, 18'h00100, 18'h0, 18'h00101, 18'h00040, 18'h20000,
    18'h10000, 18'h0, 18'h10000, 18'h00010, 18'h00012, 18'h0};
  int            reps_tab [19] = '{1, 1, 1, 1, 1, 1, 1, 1, 2, 1, 1, 1, 1, 80, 79, 1, 1, 1, 1};

  frs_result_status DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_dor_wr(dor_wr),
    .i_dor_reset_wdat(dor_wdat), .i_dsr_wr(dsr_wr), .i_dsr_reset_wdat(dsr_wdat),
    .i_cmd_start(cmd_start), .i_cmd_done(cmd_done), .i_term_code(term), .i_evt(evt),
    .i_result_count(cnt), .i_data_rd(host_rd), .i_cfg_wr(cfg_wr), .i_cfg_poll_off(cfg_off),
    .i_write_protect(wp), .i_track_zero_in(t0), .i_head_select_out(head),
    .i_unit_select(unit), .o_data(o_data), .o_result_ready(o_ready),
    .o_core_reset(o_core_reset), .o_dor_reset(o_dor_reset), .o_poll_enable(o_poll),
    .o_powerdown_exit(o_pdx));
  frs_host_model host_model (.i_clk(i_clk), .i_nrst(i_nrst), .i_go(host_go),
    .i_nbytes(host_n), .i_gap(host_gap), .i_ready(o_ready), .i_data(o_data),
    .o_rd(host_rd), .o_bytes(host_bytes), .o_count(host_cnt));

  // Clock, power-down exit counter and a watchdog against hangs.
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_pdx === 1'b1) pdx_count++;
  initial begin
    #1_000_000;
    failures++;
    finish_test();
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  // Builds the four expected bytes from the pins that stand at termination.
  function automatic logic [31:0] mk(input logic [1:0] tc, input logic [1:0] f0,
                                     input logic [7:0] s1, input logic [7:0] s2);
    return {1'b0, wp, 1'b1, t0, 1'b1, head, unit, s2, s1, tc, f0, 1'b0, head, unit};
  endfunction : mk

  // One fault event per table entry; entries above 15 offer an ID track.
  function automatic frs_event_type ev_of(input int k);
    frs_event_type e;
    e = '0;
    e.id_valid = (k > 15);
    case (k)
      0: e.sector_beyond = 1'b1;
      1: e.no_terminal = 1'b1;
      2: e.crc_id = 1'b1;
      3: e.crc_payload = 1'b1;
      4: e.overrun = 1'b1;
      5: e.sector_missing = 1'b1;
      6, 7: e.write_cmd = 1'b1;
      8, 9: e.index_pulse_in = 1'b1;
      10: e.payload_mark_miss = 1'b1;
      11: e.mark_mismatch = 1'b1;
      12: e.travel_done = 1'b1;
      13, 14: e.recal_step = 1'b1;
      15: e.step_past_zero = 1'b1;
      16: e.id_track = 8'h05;
      17: e.id_track = 8'hff;
      default: e.id_track = 8'h00;
    endcase
    return e;
  endfunction : ev_of

  task automatic done_pulse(input logic [1:0] tc, input logic [1:0] rc);
    cmd_done <= 1'b1;
    term     <= tc;
    cnt      <= rc;
    @(posedge i_clk);
    cmd_done <= 1'b0;
  endtask : done_pulse

  // Start, repeated events with a quiet cycle between them, then termination.
  task automatic run_cmd(input frs_event_type ev, input int reps, input logic [1:0] tc,
                         input logic [1:0] rc);
    @(posedge i_clk);
    cmd_start <= 1'b1;
    @(posedge i_clk);
    cmd_start <= 1'b0;
    repeat (reps) begin
      evt <= ev;
      @(posedge i_clk);
      evt <= '0;
      @(posedge i_clk);
    end
    done_pulse(tc, rc);
  endtask : run_cmd

  // Lets the host drain n bytes, then judges them and the end of the phase.
  task automatic collect(input logic [2:0] n, input logic [3:0] gap, input logic [31:0] exp);
    int i;
    host_n   <= n;
    host_gap <= gap;
    host_go  <= 1'b1;
    for (i = 0; i < 300 && host_cnt !== n; i++) @(posedge i_clk);
    host_go <= 1'b0;
    @(posedge i_clk);
    check("ready after last byte", o_ready, 8'h0);
    for (i = 0; i < n; i++) check("result byte", host_bytes[i*8 +: 8], exp[i*8 +: 8]);
  endtask : collect

  // Reset through the rate register, or release through the drive register; the core must be out again in 8 cycles.
  task automatic soft_reset(input logic use_dsr, input logic [7:0] exp_poll);
    int c0;
    c0 = pdx_count;
    @(posedge i_clk);
    dsr_wdat <= 1'b1;
    dor_wdat <= 1'b1;
    dsr_wr   <= use_dsr;
    dor_wr   <= !use_dsr;
    @(posedge i_clk);
    dsr_wr <= 1'b0;
    dor_wr <= 1'b0;
    repeat (8) @(posedge i_clk);
    check("core reset", o_core_reset, 8'h0);
    check("drive reset bit", o_dor_reset, 8'h0);
    check("power-down exits", 8'(pdx_count - c0), 8'h1);
    check("polling", o_poll, exp_poll);
  endtask : soft_reset

  // Every termination code and fault flag, with varied pins and fast and slow reads.
  task automatic event_table();
    for (int k = 0; k < 19; k++) begin
      @(posedge i_clk);
      wp   <= (k == 6);
      t0   <= (k > 15);
      head <= k[0];
      unit <= k[2:1];
      run_cmd(ev_of(k), reps_tab[k], k[1:0], 2'h3);
      collect(3'h4, {2'h0, k[0], 1'b0}, mk(k[1:0], tab[k][17:16], tab[k][15:8], tab[k][7:0]));
    end
  endtask : event_table

  // Pins move and a second termination arrives while results are pending.
  task automatic hold_and_refuse();
    logic [31:0] exp;
    @(posedge i_clk);
    wp   <= 1'b0;
    t0   <= 1'b1;
    head <= 1'b1;
    unit <= 2'h3;
    run_cmd(ev_of(2), 1, 2'h1, 2'h3);
    exp = mk(2'h1, 2'h0, 8'h20, 8'h00);
    repeat (4) @(posedge i_clk);
    wp   <= 1'b1;
    t0   <= 1'b0;
    head <= 1'b0;
    unit <= 2'h0;
    done_pulse(2'h2, 2'h0);
    repeat (4) @(posedge i_clk);
    collect(3'h4, 4'h3, exp);
    run_cmd(ev_of(9), 1, 2'h2, 2'h0);
    collect(3'h1, 4'h0, mk(2'h2, 2'h0, 8'h00, 8'h00));
  endtask : hold_and_refuse

  // Configure, rate reset mid-result, drive reset precedence, pin reset with a result pending.
  task automatic reset_paths();
    @(posedge i_clk);
    cfg_wr  <= 1'b1;
    cfg_off <= 1'b1;
    @(posedge i_clk);
    cfg_wr <= 1'b0;
    run_cmd(ev_of(0), 1, 2'h1, 2'h3);
    repeat (4) @(posedge i_clk);
    check("polling after configure", o_poll, 8'h0);
    check("result pending", o_ready, 8'h1);
    soft_reset(1'b1, 8'h1);
    check("result dropped by reset", o_ready, 8'h0);
    dor_wr   <= 1'b1;
    dor_wdat <= 1'b0;
    @(posedge i_clk);
    dor_wr   <= 1'b0;
    dsr_wr   <= 1'b1;
    dsr_wdat <= 1'b1;
    @(posedge i_clk);
    dsr_wr <= 1'b0;
    repeat (10) @(posedge i_clk);
    check("core reset under drive reset", o_core_reset, 8'h1);
    check("drive reset bit held", o_dor_reset, 8'h1);
    soft_reset(1'b0, 8'h1);
    run_cmd(ev_of(1), 1, 2'h1, 2'h3);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    check("drive reset bit after pin reset", o_dor_reset, 8'h1);
    check("ready after pin reset", o_ready, 8'h0);
    i_nrst <= 1'b1;
    soft_reset(1'b0, 8'h1);
  endtask : reset_paths

  // Pin reset for 20 cycles, then the core is released by the host.
  initial begin
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    check("core reset after pin reset", o_core_reset, 8'h1);
    check("drive reset bit set by pin", o_dor_reset, 8'h1);
    check("polling in reset", o_poll, 8'h0);
    check("result byte in reset", o_data, 8'h0);
    soft_reset(1'b0, 8'h1);
    event_table();
    hold_and_refuse();
    reset_paths();
    finish_test();
  end
endmodule : test_frs_result_status
